// ===== stt_pkg.sv
// Package: register map, field layout and types of the standard timer
package stt_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] STT_OFS_RUN   = 8'h00;
    localparam logic [7:0] STT_OFS_CFG   = 8'h04;
    localparam logic [7:0] STT_OFS_COUNT = 8'h08;
    localparam logic [7:0] STT_OFS_CMPA  = 8'h0c;
    localparam logic [7:0] STT_OFS_CMPP  = 8'h10;
    localparam logic [7:0] STT_OFS_FLAGS = 8'h14;

    // ------------------------------------------------------------
    // Field positions, widths and reset values
    // ------------------------------------------------------------
    localparam int          STT_RUN_BIT    = 0;
    localparam int          STT_FLAG_A_BIT = 0;
    localparam int          STT_FLAG_P_BIT = 1;
    localparam int          STT_CNT_W      = 10;
    localparam int          STT_STEP_W     = 7;
    localparam logic [9:0]  STT_CNT_RST    = 10'h000;
    localparam logic [9:0]  STT_CMPA_RST   = 10'h000;
    localparam logic [2:0]  STT_CMPP_RST   = 3'h0;
    localparam logic [6:0]  STT_STEP_ZERO  = 7'h00;
    localparam logic [9:0]  STT_CNT_MAX    = 10'h3ff;

    // Output function codes
    localparam logic [1:0]  STT_FN_00 = 2'h0;
    localparam logic [1:0]  STT_FN_01 = 2'h1;
    localparam logic [1:0]  STT_FN_10 = 2'h2;
    localparam logic [1:0]  STT_FN_11 = 2'h3;

    typedef enum logic [1:0] {
        STT_MODE_CMP,
        STT_MODE_CAP,
        STT_MODE_PWM,
        STT_MODE_TC
    } stt_mode_e;

    typedef struct packed {
        stt_mode_e  mode_select;
        logic [1:0] output_function_select;
        logic       output_initial_level;
        logic       output_invert;
        logic       period_duty_swap;
        logic       counter_clear_select;
    } stt_cfg_s;

    localparam stt_cfg_s STT_CFG_RST = 8'h00;

endpackage : stt_pkg

// ===== stt_timer.sv
// Standard timer: compare, timer/counter, PWM, single pulse and capture modes
`timescale 1ns/10ps
// What this block does
// - Compare mode, clear select set: A match clears
// - Compare and timer/counter, clear select set: P flag never raised
// - Only A matches and run rising edges change the compare output
// - Run rising edge restores initial output level
// - Timer/counter mode: compare behaviour, pin released
// - PWM: swap low, P period, A duty
// - P value steps 128 clocks, zero means 1024
// - Duty at least period gives full active
// - Swap high: A period, P duty steps
// - PWM: A and P flags set independently
// - Initial level sets polarity, function, invert
// - Fixed-level functions keep PWM counter running
// - PWM ignores clear select; period register clears
// - Trigger pin edge sets run, starts pulse
// - A match ends pulse, clears run, flags
// - Single pulse: only run edge zeroes counter
// - Capture mode: counter starts on run edge
// - Capture edge copies counter into A, flags
// - Capture: P match wraps counter, flags; zero=max
// - Function code 11 disables capture only
// - Capture edge: rise, fall, both, off
// - Initial level: PWM polarity, pulse start level
module stt_timer
    import stt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        capture_input_pin,
    input  wire logic        external_clock_pin,
    output logic             wave_out,
    output logic             wave_oe
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    stt_cfg_s    cfg_ff;
    logic        run_ff;
    logic        run_prev_ff;
    logic [9:0]  cnt_ff;
    logic [9:0]  cmpa_ff;
    logic [2:0]  cmpp_ff;
    logic [1:0]  flags_ff;
    logic        wave_ff;
    logic        cap_prev_ff;
    logic        trig_prev_ff;

    logic        nxt_run_ff;
    logic [9:0]  nxt_cnt;
    logic        wr;
    logic        rd_ok;
    logic [31:0] rd_mux;
    logic [31:0] prdata_ff;
    logic        run_rise;
    logic        cmpish;
    logic        sp_mode;
    logic        pwm_mode;
    logic        cap_mode;
    logic        a_hit;
    logic        p_hit;
    logic        cnt_clear;
    logic        set_a;
    logic        set_p;
    logic        trig;
    logic        cap_evt;
    logic [10:0] duty;
    logic [10:0] period;
    logic        pwm_level;

    // ------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign wr     = psel & penable & pwrite;

    always_comb
    begin
        rd_ok  = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr[7:0])
            STT_OFS_RUN:   rd_mux[STT_RUN_BIT] = run_ff;
            STT_OFS_CFG:   rd_mux[7:0] = cfg_ff;
            STT_OFS_COUNT: rd_mux[9:0] = cnt_ff;
            STT_OFS_CMPA:  rd_mux[9:0] = cmpa_ff;
            STT_OFS_CMPP:  rd_mux[2:0] = cmpp_ff;
            STT_OFS_FLAGS: rd_mux[1:0] = flags_ff;
            default:       rd_ok = 1'b0;
        endcase
        if (paddr[31:8] != 24'h00_0000)
        begin
            rd_ok  = 1'b0;
            rd_mux = 32'h0000_0000;
        end
    end

    assign pslverr = psel & penable & ~rd_ok;

    // Read word taken in setup, so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h0000_0000;
        else if (psel && !penable)
            prdata_ff <= rd_mux;
    end

    assign prdata = prdata_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_ff  <= STT_CFG_RST;
            cmpp_ff <= STT_CMPP_RST;
        end
        else if (wr && rd_ok)
        begin
            if (paddr[7:0] == STT_OFS_CFG)
                cfg_ff <= stt_cfg_s'(pwdata[7:0]);
            if (paddr[7:0] == STT_OFS_CMPP)
                cmpp_ff <= pwdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // Mode decode and comparators
    // ------------------------------------------------------------
    assign cmpish   = (cfg_ff.mode_select == STT_MODE_CMP) |
                      (cfg_ff.mode_select == STT_MODE_TC);
    assign pwm_mode = (cfg_ff.mode_select == STT_MODE_PWM) &
                      (cfg_ff.output_function_select != STT_FN_11);
    assign sp_mode  = (cfg_ff.mode_select == STT_MODE_PWM) &
                      (cfg_ff.output_function_select == STT_FN_11);
    assign cap_mode = (cfg_ff.mode_select == STT_MODE_CAP);
    assign run_rise = run_ff & ~run_prev_ff;
    assign nxt_cnt  = cnt_ff + 10'h001;

    // Hits look one count ahead, so the clear replaces the matching count
    assign a_hit = run_ff & ~run_rise & (nxt_cnt == cmpa_ff);
    // Zero in the step field matches only the full-count wrap
    assign p_hit = run_ff & ~run_rise & (nxt_cnt[6:0] == STT_STEP_ZERO) &
                   (nxt_cnt[9:7] == cmpp_ff);

    always_comb
    begin
        cnt_clear = 1'b0;
        set_a     = 1'b0;
        set_p     = 1'b0;
        if (cmpish)
        begin
            // Zero in A raises no A event, though it would match at the count wrap
            set_a     = a_hit & (cmpa_ff != STT_CMPA_RST);
            set_p     = p_hit & ~cfg_ff.counter_clear_select;
            cnt_clear = cfg_ff.counter_clear_select ? set_a : p_hit;
        end
        else if (pwm_mode)
        begin
            set_a     = a_hit;
            set_p     = p_hit;
            cnt_clear = cfg_ff.period_duty_swap ? a_hit : p_hit;
        end
        else if (sp_mode)
            set_a = a_hit;
        else
        begin
            set_a     = cap_evt;
            set_p     = p_hit;
            cnt_clear = p_hit;
        end
    end

    // ------------------------------------------------------------
    // Run control and counter
    // ------------------------------------------------------------
    assign trig = external_clock_pin & ~trig_prev_ff;

    always_comb
    begin
        nxt_run_ff = run_ff;
        if (wr && paddr[7:0] == STT_OFS_RUN && paddr[31:8] == 24'h00_0000)
            nxt_run_ff = pwdata[STT_RUN_BIT];
        if (sp_mode && a_hit)
            nxt_run_ff = 1'b0;
        if (sp_mode && trig)
            nxt_run_ff = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_ff       <= 1'b0;
            run_prev_ff  <= 1'b0;
            trig_prev_ff <= 1'b0;
            cap_prev_ff  <= 1'b0;
        end
        else
        begin
            run_ff       <= nxt_run_ff;
            run_prev_ff  <= run_ff;
            trig_prev_ff <= external_clock_pin;
            cap_prev_ff  <= capture_input_pin;
        end
    end

    // Counter runs in every mode, including fixed-level PWM
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_ff <= STT_CNT_RST;
        else if (run_rise)
            cnt_ff <= STT_CNT_RST;
        else if (run_ff)
            cnt_ff <= cnt_clear ? STT_CNT_RST : nxt_cnt;
    end

    // ------------------------------------------------------------
    // Capture and flags
    // ------------------------------------------------------------
    always_comb
    begin
        case (cfg_ff.output_function_select)
            STT_FN_00: cap_evt = capture_input_pin & ~cap_prev_ff;
            STT_FN_01: cap_evt = ~capture_input_pin & cap_prev_ff;
            STT_FN_10: cap_evt = capture_input_pin ^ cap_prev_ff;
            default:   cap_evt = 1'b0;
        endcase
        cap_evt = cap_evt & cap_mode;
    end

    // Capture wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmpa_ff <= STT_CMPA_RST;
        else if (cap_evt)
            cmpa_ff <= cnt_ff;
        else if (wr && rd_ok && paddr[7:0] == STT_OFS_CMPA)
            cmpa_ff <= pwdata[9:0];
    end

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_ff <= 2'h0;
        else
        begin
            if (wr && rd_ok && paddr[7:0] == STT_OFS_FLAGS)
                flags_ff <= flags_ff & ~pwdata[1:0];
            if (set_a)
                flags_ff[STT_FLAG_A_BIT] <= 1'b1;
            if (set_p)
                flags_ff[STT_FLAG_P_BIT] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Waveform output
    // ------------------------------------------------------------
    assign duty   = cfg_ff.period_duty_swap ?
                    {(cmpp_ff == STT_CMPP_RST), cmpp_ff, STT_STEP_ZERO} :
                    {1'b0, cmpa_ff};
    assign period = cfg_ff.period_duty_swap ?
                    {(cmpa_ff == STT_CMPA_RST), cmpa_ff} :
                    {(cmpp_ff == STT_CMPP_RST), cmpp_ff, STT_STEP_ZERO};
    // Counter never reaches the period, so duty >= period is full active
    assign pwm_level = ({1'b0, cnt_ff} < duty) | (duty >= period);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wave_ff <= 1'b0;
        else if (run_rise)
            wave_ff <= cfg_ff.output_initial_level;
        else if (cmpish)
        begin
            if (set_a)
            begin
                case (cfg_ff.output_function_select)
                    STT_FN_01: wave_ff <= 1'b0;
                    STT_FN_10: wave_ff <= 1'b1;
                    STT_FN_11: wave_ff <= ~wave_ff;
                    default:   wave_ff <= wave_ff;
                endcase
            end
        end
        else if (pwm_mode)
        begin
            case (cfg_ff.output_function_select)
                STT_FN_00: wave_ff <= ~cfg_ff.output_initial_level;
                STT_FN_01: wave_ff <= cfg_ff.output_initial_level;
                default:   wave_ff <= pwm_level ? cfg_ff.output_initial_level :
                                                  ~cfg_ff.output_initial_level;
            endcase
        end
        else if (sp_mode)
            wave_ff <= nxt_run_ff ? cfg_ff.output_initial_level :
                                    ~cfg_ff.output_initial_level;
    end

    assign wave_out = wave_ff ^ cfg_ff.output_invert;
    assign wave_oe  = (cfg_ff.mode_select == STT_MODE_CMP) | pwm_mode | sp_mode;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_cmp_clear_a: assert property (
        cmpish && cfg_ff.counter_clear_select && a_hit && cmpa_ff != 10'h000
        |=> cnt_ff == 10'h000)
        else $error("A match did not clear counter");
    chk_no_p_flag: assert property (
        cmpish && cfg_ff.counter_clear_select |=> !$rose(flags_ff[1]))
        else $error("P flag raised with clear select set");
    chk_wave_hold: assert property (
        cfg_ff.mode_select == STT_MODE_CMP && !run_rise && !set_a
        |=> $stable(wave_ff))
        else $error("Compare output moved without A match");
    chk_rise_init: assert property (
        run_rise |=> wave_ff == $past(cfg_ff.output_initial_level))
        else $error("Output not at initial level after run edge");
    chk_tc_release: assert property (
        cfg_ff.mode_select == STT_MODE_TC |-> !wave_oe)
        else $error("Pin driven in timer counter mode");
    chk_pwm_full: assert property (
        pwm_mode && cfg_ff.output_function_select == STT_FN_10 && !run_rise &&
        duty >= period |=> wave_ff == $past(cfg_ff.output_initial_level))
        else $error("Full duty not held active");
    chk_sp_trigger: assert property (
        sp_mode && trig && !run_ff |=> run_ff ##1 cnt_ff == STT_CNT_RST)
        else $error("Trigger did not start pulse");
    chk_sp_stop: assert property (
        sp_mode && a_hit && !trig |=> !run_ff && flags_ff[0])
        else $error("A match did not end pulse");
    chk_capture: assert property (
        cap_evt |=> cmpa_ff == $past(cnt_ff) && flags_ff[0])
        else $error("Capture did not latch counter");
    chk_p_wrap: assert property (
        p_hit && cmpp_ff == STT_CMPP_RST |-> cnt_ff == STT_CNT_MAX)
        else $error("Zero P matched before wrap");

    cov_pwm_period:  cover property (pwm_mode && cnt_clear ##1 pwm_mode);
    cov_pulse_done:  cover property (sp_mode && trig ##[1:200] sp_mode && a_hit);
    cov_capture:     cover property (cap_evt);
    cov_cmp_clear:   cover property (cmpish && cnt_clear && set_a);

endmodule : stt_timer

// ===== stt_pin_model.sv
// Pin-side partner of the timer: capture source and pulse trigger
`timescale 1ns/10ps
module stt_pin_model
(
    input  wire logic pclk,
    output logic      capture_input_pin,
    output logic      external_clock_pin
);
    initial
    begin
        capture_input_pin  = 1'b0;
        external_clock_pin = 1'b0;
    end

    // Level stays until the next call, like a slow sensor line
    task automatic set_cap(input logic v);
        @(posedge pclk);
        capture_input_pin <= v;
    endtask : set_cap

    // Hold sets how long the far side keeps the trigger high
    task automatic trigger(input int hold);
        @(posedge pclk);
        external_clock_pin <= 1'b1;
        repeat (hold) @(posedge pclk);
        external_clock_pin <= 1'b0;
    endtask : trigger
endmodule : stt_pin_model

// ===== tb.sv
// Self-checking bench for the standard timer modes
`timescale 1ns/10ps
module tb
    import stt_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cap_pin;
    logic        trig_pin;
    logic        wave_out;
    logic        wave_oe;
    logic [31:0] rd;
    logic        err;
    int          fail_count;
    int          check_count;

    stt_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_input_pin(cap_pin),
        .external_clock_pin(trig_pin), .wave_out(wave_out), .wave_oe(wave_oe));
    stt_pin_model pins (.pclk(pclk), .capture_input_pin(cap_pin),
        .external_clock_pin(trig_pin));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic bound(input int n, input int lim);
        if (n > lim)
        begin
            fail_count++;
            end_of_test();
        end
    endtask : bound

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
            bound(n, 20);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Config changes only with the counter stopped
    task automatic run_cfg(input logic [7:0] c, input logic [9:0] a, input logic [2:0] p);
        apb(1'b1, STT_OFS_RUN, 32'h0);
        apb(1'b1, STT_OFS_CFG, {24'h0, c});
        apb(1'b1, STT_OFS_CMPA, {22'h0, a});
        apb(1'b1, STT_OFS_CMPP, {29'h0, p});
        apb(1'b1, STT_OFS_FLAGS, 32'h3);
        apb(1'b1, STT_OFS_RUN, 32'h1);
    endtask : run_cfg

    task automatic wait_flags(input logic [31:0] m);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, STT_OFS_FLAGS, 32'h0);
            n++;
            bound(n, 700);
        end
        while ((rd & m) == 32'h0);
    endtask : wait_flags

    task automatic pulse_width(input string nm);
        int n;
        n = 0;
        while (wave_out !== 1'b1)
        begin
            @(posedge pclk);
            n++;
            bound(n, 60);
        end
        n = 0;
        while (wave_out === 1'b1 && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        // Pin leads counter zero by a cycle: width is CMPA plus one
        chk_word(nm, 32'd51, 32'(n));
    endtask : pulse_width

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk_word("oe at reset", 32'h1, {31'h0, wave_oe});
        chk_word("wave at reset", 32'h0, {31'h0, wave_out});
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk_word("reset value", 32'h0, rd);
        end
        apb(1'b1, 8'h18, 32'h1);
        chk_word("unmapped error", 32'h1, {31'h0, err});
    endtask : t_reset

    task automatic t_compare;
        logic [7:0] cm[3] = '{8'h09, 8'h19, 8'h21};
        logic       ex[3] = '{1'b1, 1'b0, 1'b1};
        // No change, drive low, drive high on an A match
        for (int i = 0; i < 3; i++)
        begin
            run_cfg(cm[i], 10'd200, 3'h1);
            wait_flags(32'h1);
            chk_word("cmp level", {31'h0, ex[i]}, {31'h0, wave_out});
        end
        // Toggle, initial high, A clears; P step lies below A
        run_cfg(8'h39, 10'd200, 3'h1);
        wait_flags(32'h1);
        chk_word("flags clear sel", 32'h1, rd);
        chk_word("wave toggled", 32'h0, {31'h0, wave_out});
        apb(1'b1, STT_OFS_RUN, 32'h0);
        apb(1'b1, STT_OFS_RUN, 32'h1);
        repeat (3) @(posedge pclk);
        chk_word("wave restored", 32'h1, {31'h0, wave_out});
        repeat (250) @(posedge pclk);
        apb(1'b0, STT_OFS_COUNT, 32'h0);
        chk_word("count below A", 32'h1, {31'h0, rd < 200});
        // A of zero never matches, so only P events occur
        run_cfg(8'h38, 10'd0, 3'h1);
        wait_flags(32'h2);
        chk_word("p flag only", 32'h2, rd);
        chk_word("wave kept", 32'h1, {31'h0, wave_out});
        run_cfg(8'hf9, 10'd200, 3'h1);
        wait_flags(32'h1);
        chk_word("tc flags", 32'h1, rd);
        chk_word("tc pin released", 32'h0, {31'h0, wave_oe});
    endtask : t_compare

    task automatic t_pwm;
        logic [7:0] cf[8] = '{8'ha9, 8'hac, 8'ha0, 8'ha8, 8'haa, 8'ha8, 8'h88, 8'h98};
        logic [9:0] ca[8] = '{10'd32, 10'd32, 10'd32, 10'd200, 10'd300, 10'd256,
                              10'd32, 10'd32};
        logic [2:0] cp[8] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h1, 3'h1};
        int         win[8] = '{256, 256, 256, 256, 600, 1024, 256, 256};
        int         hi[8] = '{64, 192, 192, 256, 256, 256, 0, 256};
        logic [1:0] fl[8] = '{2'h3, 2'h3, 2'h3, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};
        int         n;
        for (int i = 0; i < 8; i++)
        begin
            run_cfg(cf[i], ca[i], cp[i]);
            repeat (8) @(posedge pclk);
            n = 0;
            repeat (win[i])
            begin
                @(posedge pclk);
                n += (wave_out === 1'b1);
            end
            chk_word("pwm high count", 32'(hi[i]), 32'(n));
            apb(1'b0, STT_OFS_FLAGS, 32'h0);
            chk_word("pwm flags", {30'h0, fl[i]}, rd);
        end
    endtask : t_pwm

    task automatic t_pulse;
        // Clear select and swap set, P nonzero: all ignored here
        run_cfg(8'hbb, 10'd50, 3'h7);
        pulse_width("soft pulse");
        apb(1'b0, STT_OFS_COUNT, 32'h0);
        chk_word("count held", 32'h1, {31'h0, rd >= 49});
        apb(1'b1, STT_OFS_FLAGS, 32'h3);
        fork
            pins.trigger(3);
            pulse_width("pin pulse");
        join
        apb(1'b0, STT_OFS_RUN, 32'h0);
        chk_word("run cleared", 32'h0, rd);
        apb(1'b0, STT_OFS_FLAGS, 32'h0);
        chk_word("pulse flag", 32'h1, rd);
        pins.trigger(1);
        repeat (10) @(posedge pclk);
        chk_word("pulse running", 32'h1, {31'h0, wave_out});
        apb(1'b1, STT_OFS_RUN, 32'h0);
        repeat (2) @(posedge pclk);
        chk_word("soft end", 32'h0, {31'h0, wave_out});
    endtask : t_pulse

    task automatic t_capture;
        logic ex_r[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        logic ex_f[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        for (int f = 0; f < 4; f++)
        begin
            run_cfg({2'b01, 2'(f), 4'h0}, 10'h0, 3'h0);
            repeat (20) @(posedge pclk);
            pins.set_cap(1'b1);
            repeat (4) @(posedge pclk);
            apb(1'b0, STT_OFS_FLAGS, 32'h0);
            chk_word("rise flag", {31'h0, ex_r[f]}, rd);
            apb(1'b0, STT_OFS_CMPA, 32'h0);
            chk_word("cmpa loaded", {31'h0, ex_r[f]}, {31'h0, rd != 0});
            apb(1'b0, STT_OFS_COUNT, 32'h0);
            chk_word("count runs", 32'h1, {31'h0, rd != 0});
            apb(1'b1, STT_OFS_FLAGS, 32'h3);
            pins.set_cap(1'b0);
            repeat (4) @(posedge pclk);
            apb(1'b0, STT_OFS_FLAGS, 32'h0);
            chk_word("fall flag", {31'h0, ex_f[f]}, rd);
        end
        run_cfg(8'h40, 10'h0, 3'h1);
        repeat (300) @(posedge pclk);
        apb(1'b0, STT_OFS_FLAGS, 32'h0);
        chk_word("p wrap flag", 32'h2, rd);
        apb(1'b0, STT_OFS_COUNT, 32'h0);
        chk_word("wrapped count", 32'h1, {31'h0, rd < 128});
    endtask : t_capture

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        fail_count = 0;
        check_count = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_compare();
        t_pwm();
        t_pulse();
        t_capture();
        end_of_test();
    end
endmodule : tb
